// >>> regulator_and_wake_pin_control.sv
// Digital control of the analog, core and USB regulators and of the wake pin.
// Assumes the always-on clock domain, straps and wake pin asynchronous to aclk,
// and an AXI4-Lite master issuing at most one read and one write at a time.
//
// Functional notes
// - Either power-down bit turns all regulators off.
// - Software power-down holds until power-on reset.
// - Analog regulator always on unless powered down.
// - High core enable strap disables, tristates core.
// - Core voltage selectable, 1.3 V after reset.
// - Clock strap high: USB off, software switchable.
// - Clock strap low: USB on unless powered down.
// - Wake value 0 drives low, 1 releases.
// - Wake direction 0 input, 1 output.
// - Input wake pin is active high.
// - Pin wakes device only as input.
// - Reserved upper bits read zero, ignore writes.
// - Bandgap bit also stops bandgap and POR.
`timescale 1ns/1ps
module regulator_and_wake_pin_control (
  // Clock and reset.
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // AXI4-Lite write address and data.
  input  wire logic                         awvalid,
  output logic                              awready,
  input  wire logic [15:0]                  awaddr,
  input  wire logic [2:0]                   awprot,
  input  wire logic                         wvalid,
  output logic                              wready,
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  // AXI4-Lite write response.
  output logic                              bvalid,
  input  wire logic                         bready,
  output logic [1:0]                        bresp,
  // AXI4-Lite read.
  input  wire logic                         arvalid,
  output logic                              arready,
  input  wire logic [15:0]                  araddr,
  input  wire logic [2:0]                   arprot,
  output logic                              rvalid,
  input  wire logic                         rready,
  output logic [31:0]                       rdata,
  output logic [1:0]                        rresp,
  // Board straps.
  input  wire logic                         core_regulator_enable_n,
  input  wire logic                         clock_source_strap,
  // Wake pin, split into input, output and active-low output enable.
  input  wire logic                         wake_pin_in,
  output logic                              wake_pin_out,
  output logic                              wake_pin_oe_n,
  output logic                              wake_request,
  // Regulator enables.
  output regulator_and_wake_pin_control_pkg::regulator_ctrl_s regulators
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.
  logic        aw_got_r;
  logic        w_got_r;
  logic [15:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        reg_pd_r;
  logic        bandgap_powerdown_r;
  logic        wake_dir_r;
  logic        wake_val_r;
  logic        usb_on_r;
  logic        vsel_r;
  logic        core_strap_meta_r;
  logic        core_strap_sync_r;
  logic        clk_strap_meta_r;
  logic        clk_strap_sync_r;
  logic        wake_meta_r;
  logic        wake_sync_r;
  logic [1:0]  settle_cnt_r;
  logic        strap_done_r;
  logic        clk_strap_r;
  logic        wake_out_r;
  logic        wake_oe_n_r;
  logic        wake_request_r;
  regulator_and_wake_pin_control_pkg::regulator_ctrl_s regs_r;
  regulator_and_wake_pin_control_pkg::regulator_ctrl_s regs_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode and write enables.
  wire        wr_fire     = aw_got_r && w_got_r && !bvalid_r;
  wire        wr_pmgt     = wr_fire && (aw_addr_r == regulator_and_wake_pin_control_pkg::PMGT_OFFSET);
  wire        wr_ctrl     = wr_fire && (aw_addr_r == regulator_and_wake_pin_control_pkg::CTRL_OFFSET);
  wire        wr_status   = wr_fire && (aw_addr_r == regulator_and_wake_pin_control_pkg::STATUS_OFFSET);
  wire        wr_mapped   = wr_pmgt || wr_ctrl || wr_status;
  wire        wr_lane0    = w_strb_r[0];
  wire        rd_fire     = arvalid && arready_r;
  wire        rd_pmgt     = (araddr == regulator_and_wake_pin_control_pkg::PMGT_OFFSET);
  wire        rd_ctrl     = (araddr == regulator_and_wake_pin_control_pkg::CTRL_OFFSET);
  wire        rd_status   = (araddr == regulator_and_wake_pin_control_pkg::STATUS_OFFSET);
  wire        regs_off    = reg_pd_r || bandgap_powerdown_r;

  // Read views; every bit not listed reads as zero.
  wire [15:0] pmgt_view   = {11'h000, wake_val_r, wake_dir_r, bandgap_powerdown_r, reg_pd_r, 1'b0};
  wire [15:0] ctrl_view   = {14'h0000, vsel_r, usb_on_r};
  wire [15:0] status_view = {10'h000, usb_on_r, wake_sync_r, clk_strap_r, core_strap_sync_r, bandgap_powerdown_r, regs_off};
  wire [15:0] rd_view     = rd_pmgt ? pmgt_view : rd_ctrl ? ctrl_view : rd_status ? status_view : 16'h0000;
  wire        rd_mapped   = rd_pmgt || rd_ctrl || rd_status;

  ////////////////////////////////////////////////////////////////////////////////
  // Write address and data are caught independently and released after the response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_addr_r <= 16'h0000;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (awvalid && awready_r) begin
        aw_got_r  <= 1'b1;
        awready_r <= 1'b0;
        aw_addr_r <= awaddr;
      end else if (bvalid_r && bready) begin
        aw_got_r  <= 1'b0;
        awready_r <= 1'b1;
      end
      if (wvalid && wready_r) begin
        w_got_r  <= 1'b1;
        wready_r <= 1'b0;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end else if (bvalid_r && bready) begin
        w_got_r  <= 1'b0;
        wready_r <= 1'b1;
      end
    end
  end

  // Write response, one cycle after both halves are held; unmapped gives SLVERR.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= regulator_and_wake_pin_control_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_mapped ? regulator_and_wake_pin_control_pkg::RESP_OKAY
                            : regulator_and_wake_pin_control_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read path answers one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= regulator_and_wake_pin_control_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= {16'h0000, rd_view};
      rresp_r   <= rd_mapped ? regulator_and_wake_pin_control_pkg::RESP_OKAY
                             : regulator_and_wake_pin_control_pkg::RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power-down bits only ever set; a zero write cannot bring the regulators back,
  // so only the always-on power-on reset clears them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg_pd_r   <= regulator_and_wake_pin_control_pkg::PD_RESET;
      bandgap_powerdown_r    <= regulator_and_wake_pin_control_pkg::PD_RESET;
      wake_dir_r <= regulator_and_wake_pin_control_pkg::WAKE_DIR_RESET;
      wake_val_r <= regulator_and_wake_pin_control_pkg::WAKE_VAL_RESET;
    end else if (wr_pmgt && wr_lane0) begin
      reg_pd_r   <= reg_pd_r | w_data_r[regulator_and_wake_pin_control_pkg::REG_PD_BIT];
      bandgap_powerdown_r    <= bandgap_powerdown_r | w_data_r[regulator_and_wake_pin_control_pkg::BANDGAP_POWERDOWN_BIT];
      wake_dir_r <= w_data_r[regulator_and_wake_pin_control_pkg::WAKE_DIR_BIT];
      wake_val_r <= w_data_r[regulator_and_wake_pin_control_pkg::WAKE_VAL_BIT];
    end
  end

  // USB enable takes its reset state from the clock strap once it has settled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_on_r <= 1'b0;
      vsel_r   <= regulator_and_wake_pin_control_pkg::VSEL_RESET;
    end else begin
      if (!strap_done_r) begin
        usb_on_r <= (settle_cnt_r == regulator_and_wake_pin_control_pkg::STRAP_SETTLE_CYCLES)
                    && !clk_strap_sync_r;
      end else if (!clk_strap_r) begin
        usb_on_r <= 1'b1;
      end else if (wr_ctrl && wr_lane0) begin
        usb_on_r <= w_data_r[regulator_and_wake_pin_control_pkg::USB_ON_BIT];
      end
      if (wr_ctrl && wr_lane0) begin
        vsel_r <= w_data_r[regulator_and_wake_pin_control_pkg::VSEL_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for straps and wake pin.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_strap_meta_r <= 1'b1;
      core_strap_sync_r <= 1'b1;
      clk_strap_meta_r  <= 1'b1;
      clk_strap_sync_r  <= 1'b1;
      wake_meta_r       <= 1'b0;
      wake_sync_r       <= 1'b0;
    end else begin
      core_strap_meta_r <= core_regulator_enable_n;
      core_strap_sync_r <= core_strap_meta_r;
      clk_strap_meta_r  <= clock_source_strap;
      clk_strap_sync_r  <= clk_strap_meta_r;
      wake_meta_r       <= wake_pin_in;
      wake_sync_r       <= wake_meta_r;
    end
  end

  // Clock strap is captured once, after the synchroniser has filled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
      clk_strap_r  <= 1'b1;
    end else if (!strap_done_r) begin
      if (settle_cnt_r == regulator_and_wake_pin_control_pkg::STRAP_SETTLE_CYCLES) begin
        strap_done_r <= 1'b1;
        clk_strap_r  <= clk_strap_sync_r;
      end else begin
        settle_cnt_r <= settle_cnt_r + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Regulator enables.  The core regulator follows its synchronised strap continuously.
  always_comb begin
    regs_nxt            = '0;
    regs_nxt.analog_en  = !regs_off;
    regs_nxt.core_en    = !regs_off && !core_strap_sync_r;
    regs_nxt.core_hiz   = regs_off || core_strap_sync_r;
    regs_nxt.core_vsel  = vsel_r;
    regs_nxt.usb_en     = !regs_off && usb_on_r;
    regs_nxt.bandgap_en = !bandgap_powerdown_r;
    regs_nxt.por_en     = !bandgap_powerdown_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regs_r <= '0;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // Wake pin: open drain, only pulled low as an output with value zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_out_r     <= 1'b0;
      wake_oe_n_r    <= 1'b1;
      wake_request_r <= 1'b0;
    end else begin
      wake_out_r     <= 1'b0;
      wake_oe_n_r    <= !(wake_dir_r && !wake_val_r);
      wake_request_r <= !wake_dir_r && wake_sync_r;
    end
  end

  // Outputs are the flip-flops above.
  assign awready       = awready_r;
  assign wready        = wready_r;
  assign bvalid        = bvalid_r;
  assign bresp         = bresp_r;
  assign arready       = arready_r;
  assign rvalid        = rvalid_r;
  assign rdata         = rdata_r;
  assign rresp         = rresp_r;
  assign wake_pin_out  = wake_out_r;
  assign wake_pin_oe_n = wake_oe_n_r;
  assign wake_request  = wake_request_r;
  assign regulators    = regs_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the behaviour above.
  a_pd_all_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_pmgt && wr_lane0 && (w_data_r[2] || w_data_r[1]))
      |-> ##2 (!regulators.analog_en && !regulators.core_en && !regulators.usb_en))
    else $error("Power-down write did not stop all regulators.");

  a_pd_sticky_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    regs_off |=> regs_off [*4])
    else $error("Regulator power-down was released without reset.");

  a_analog_stays_on: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!regs_off) [*2] |=> regulators.analog_en)
    else $error("Analog regulator dropped while not powered down.");

  a_core_strap_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (aresetn && core_strap_sync_r) |=> (!regulators.core_en && regulators.core_hiz))
    else $error("Core regulator enabled with strap high.");

  a_vsel_reset_value: assert property (
    @(posedge aclk)
    $rose(aresetn) |-> (!regulators.core_vsel && !vsel_r))
    else $error("Core voltage select not at 1.3 V after reset.");

  a_vsel_follows_write: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_ctrl && wr_lane0) |-> ##2 (regulators.core_vsel == $past(w_data_r[1], 2)))
    else $error("Core voltage select did not follow the write.");

  a_usb_strap_high: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (strap_done_r && clk_strap_r && wr_ctrl && wr_lane0)
      |=> (usb_on_r == $past(w_data_r[0])))
    else $error("USB enable ignored software with clock strap high.");

  a_usb_strap_low: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (strap_done_r && !clk_strap_r) |-> ##1 usb_on_r [*3])
    else $error("USB regulator disabled with clock strap low.");

  a_wake_drive: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wake_dir_r && !wake_val_r) |=> (!wake_pin_oe_n && !wake_pin_out))
    else $error("Wake pin not driven low as output with value zero.");

  a_wake_release: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!wake_dir_r || wake_val_r) |=> wake_pin_oe_n)
    else $error("Wake pin driven while input or released.");

  a_wake_input_only: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wake_request |-> ($past(!wake_dir_r) && $past(wake_sync_r)))
    else $error("Wake request raised while pin is an output.");

  a_wake_active_high: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!wake_dir_r && wake_meta_r) ##1 !wake_dir_r |=> wake_request)
    else $error("High input on wake pin gave no request.");

  a_reserved_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rd_fire && rd_pmgt) |=> (rdata[31:5] == 27'h0 && !rdata[0]))
    else $error("Reserved power management bits read nonzero.");

  a_bg_stops_refs: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_pmgt && wr_lane0 && w_data_r[2]) |-> ##2 (!regulators.bandgap_en && !regulators.por_en))
    else $error("Bandgap power-down left bandgap or POR running.");

  a_pd_reset_zero: assert property (
    @(posedge aclk)
    $rose(aresetn) |-> (!reg_pd_r && !bandgap_powerdown_r))
    else $error("Power-down bits not zero after reset.");

  a_bresp_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (bvalid && !bready) |=> (bvalid && $stable(bresp)))
    else $error("Write response dropped before it was taken.");

endmodule : regulator_and_wake_pin_control

// >>> regulator_and_wake_pin_control_pkg.sv
// Package for the regulator and wake pin control block.
// Holds the register map, field positions, reset values and output carrier types.
// Assumes a 16-bit byte address slice of an AXI4-Lite bus with 32-bit data.
package regulator_and_wake_pin_control_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte addresses.
  localparam int unsigned ADDR_W               = 16;
  localparam logic [15:0] PMGT_OFFSET          = 16'h1930;
  localparam logic [15:0] CTRL_OFFSET          = 16'h1940;
  localparam logic [15:0] STATUS_OFFSET        = 16'h1944;

  ////////////////////////////////////////////////////////////////////////////////
  // Power management register fields.
  localparam int unsigned REG_PD_BIT           = 1;
  localparam int unsigned BANDGAP_POWERDOWN_BIT            = 2;
  localparam int unsigned WAKE_DIR_BIT         = 3;
  localparam int unsigned WAKE_VAL_BIT         = 4;
  localparam logic        PD_RESET             = 1'b0;
  localparam logic        WAKE_DIR_RESET       = 1'b0;
  localparam logic        WAKE_VAL_RESET       = 1'b0;

  // Regulator control register fields; voltage select 0 means 1.3 V, 1 means 1.05 V.
  localparam int unsigned USB_ON_BIT           = 0;
  localparam int unsigned VSEL_BIT             = 1;
  localparam logic        VSEL_RESET           = 1'b0;

  // Status register fields.
  localparam int unsigned ST_REGS_OFF_BIT      = 0;
  localparam int unsigned ST_BG_OFF_BIT        = 1;
  localparam int unsigned ST_CORE_STRAP_BIT    = 2;
  localparam int unsigned ST_CLK_STRAP_BIT     = 3;
  localparam int unsigned ST_WAKE_LEVEL_BIT    = 4;
  localparam int unsigned ST_USB_ON_BIT        = 5;

  // Cycles after reset release before synchronised straps are trusted.
  localparam logic [1:0]  STRAP_SETTLE_CYCLES  = 2'h2;

  // AXI response codes.
  localparam logic [1:0]  RESP_OKAY            = 2'h0;
  localparam logic [1:0]  RESP_SLVERR          = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Enables toward the analog regulators and references.
  typedef struct packed {
    logic analog_en;
    logic core_en;
    logic core_hiz;
    logic core_vsel;
    logic usb_en;
    logic bandgap_en;
    logic por_en;
  } regulator_ctrl_s;

endpackage : regulator_and_wake_pin_control_pkg

// >>> board_strap_and_wake_model.sv
// Board model for the straps and the pulled-up wake line.
// Assumes the bench sets the strap levels and whether an external source pulls the line low.
`timescale 1ns/1ps
module board_strap_and_wake_model (
  // Bench controls.
  input  wire logic core_strap_set,
  input  wire logic clk_strap_set,
  input  wire logic ext_pull_low,
  // Device side of the wake pin.
  input  wire logic wake_pin_out,
  input  wire logic wake_pin_oe_n,
  // Board levels toward the device.
  output logic      core_regulator_enable_n,
  output logic      clock_source_strap,
  output logic      wake_pin_in
);
  ////////////////////////////////////////////////////////////////////////////////
  // Straps are plain board ties, so they follow the bench directly.
  assign core_regulator_enable_n = core_strap_set;
  assign clock_source_strap      = clk_strap_set;
  // Either party may pull the line low; otherwise the pull-up wins, never an unknown.
  assign wake_pin_in = (!wake_pin_oe_n) ? wake_pin_out : !ext_pull_low;
endmodule : board_strap_and_wake_model

// >>> regulator_and_wake_pin_control_bench.sv
// Self-checking bench for the regulator and wake pin control block.
// Assumes the board model file is compiled first and the design answers as its note states.
`timescale 1ns/1ps
module regulator_and_wake_pin_control_bench;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [15:0] awaddr = 16'h0, araddr = 16'h0;
  logic [31:0] wdata = 32'h0, rdata, d, v;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, wake_pin_out, wake_pin_oe_n, wake_request;
  logic        core_n, clk_strap, wake_pin_in, core_set = 1'b0, clk_set = 1'b1, ext_low = 1'b0;
  integer      seed, miscompares = 0, check_count = 0, i;
  regulator_and_wake_pin_control_pkg::regulator_ctrl_s regulators;
  localparam logic [15:0] PM = regulator_and_wake_pin_control_pkg::PMGT_OFFSET;
  localparam logic [15:0] RC = regulator_and_wake_pin_control_pkg::CTRL_OFFSET;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 50 ns and the watchdog, sized well above the run of under two hundred cycles.
  always #25 aclk = ~aclk;
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares = miscompares + 1;
    results();
  end

  regulator_and_wake_pin_control dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .core_regulator_enable_n(core_n), .clock_source_strap(clk_strap), .wake_pin_in(wake_pin_in),
    .wake_pin_out(wake_pin_out), .wake_pin_oe_n(wake_pin_oe_n), .wake_request(wake_request),
    .regulators(regulators));
  board_strap_and_wake_model board (.core_strap_set(core_set), .clk_strap_set(clk_set), .ext_pull_low(ext_low),
    .wake_pin_out(wake_pin_out), .wake_pin_oe_n(wake_pin_oe_n), .core_regulator_enable_n(core_n),
    .clock_source_strap(clk_strap), .wake_pin_in(wake_pin_in));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks; every driver change lands by non-blocking assignment right after an edge.
  task ticks(input int n);
    repeat (n) @(posedge aclk);
  endtask : ticks
  task do_reset(input logic clk_strap_level);
    aresetn <= 1'b0;
    clk_set <= clk_strap_level;
    ticks(10);
    aresetn <= 1'b1;
    ticks(8);
  endtask : do_reset
  // Write address and data are offered together and each is dropped once taken.
  task axi_write(input logic [15:0] a, input logic [31:0] dat, output logic [1:0] resp);
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    ticks(3);
  endtask : axi_write
  task axi_read(input logic [15:0] a, output logic [31:0] dat, output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    dat = rdata;
    resp = rresp;
    rready <= 1'b0;
    ticks(1);
  endtask : axi_read
  task cmp_bit(input string what, input logic exp, input logic got);
    check_count = check_count + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : cmp_bit
  task cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : cmp_word
  // Power management readback with the power-down bits still clear; reserved bits read zero.
  function automatic logic [31:0] pmgt_expect(input logic [31:0] w);
    return {27'h0, w[4:3], 3'h0};
  endfunction : pmgt_expect
  task results();
    $display("checks %0d, miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset state, straps, random control writes, wake pin, unmapped, power-down.
  initial begin
    seed = 32'h6d3e;
    do_reset(1'b1);
    cmp_bit("analog_en", 1'b1, regulators.analog_en);
    cmp_bit("core_en", 1'b1, regulators.core_en);
    cmp_bit("core_vsel", 1'b0, regulators.core_vsel);
    cmp_bit("usb_en", 1'b0, regulators.usb_en);
    axi_read(PM, d, r);
    cmp_word("pmgt reset", 32'h0, d);
    cmp_word("pmgt rresp", 32'h0, {30'h0, r});
    // Status after reset: clock strap captured high, wake line pulled up, all else clear.
    axi_read(regulator_and_wake_pin_control_pkg::STATUS_OFFSET, d, r);
    cmp_word("status reset", 32'h18, d);
    core_set <= 1'b1;
    ticks(6);
    cmp_bit("core_en", 1'b0, regulators.core_en);
    cmp_bit("core_hiz", 1'b1, regulators.core_hiz);
    core_set <= 1'b0;
    // Random control words; only bits 0 and 1 carry meaning.
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      axi_write(RC, v, r);
      cmp_bit("usb_en", v[0], regulators.usb_en);
      cmp_bit("core_vsel", v[1], regulators.core_vsel);
    end
    // A write without byte lane 0 must leave the control register alone.
    wstrb <= 4'hE;
    axi_write(RC, ~v, r);
    wstrb <= 4'hF;
    cmp_bit("core_vsel", v[1], regulators.core_vsel);
    v = $random(seed);
    v = (v & 32'hFFFFFFE0) | 32'h08;
    axi_write(PM, v, r);
    ticks(3);
    cmp_bit("oe_n", 1'b0, wake_pin_oe_n);
    cmp_bit("wake_pin_out", 1'b0, wake_pin_out);
    cmp_bit("wake_request", 1'b0, wake_request);
    axi_read(PM, d, r);
    cmp_word("pmgt readback", pmgt_expect(v), d);
    axi_write(PM, 32'h18, r);
    cmp_word("pmgt bresp", 32'h0, {30'h0, r});
    ticks(3);
    cmp_bit("oe_n", 1'b1, wake_pin_oe_n);
    cmp_bit("wake_request", 1'b0, wake_request);
    axi_write(PM, 32'h00, r);
    ticks(3);
    cmp_bit("wake_request", 1'b1, wake_request);
    ext_low <= 1'b1;
    ticks(5);
    cmp_bit("wake_request", 1'b0, wake_request);
    ext_low <= 1'b0;
    axi_read(16'h0100, d, r);
    cmp_word("unmapped rresp", 32'h2, {30'h0, r});
    cmp_word("unmapped rdata", 32'h0, d);
    axi_write(16'h0100, 32'h1E, r);
    cmp_word("unmapped bresp", 32'h2, {30'h0, r});
    // Power-down by the regulator bit, then try to undo it.
    axi_write(PM, 32'h02, r);
    cmp_bit("analog_en", 1'b0, regulators.analog_en);
    cmp_bit("core_en", 1'b0, regulators.core_en);
    axi_write(PM, 32'h00, r);
    axi_write(RC, 32'h01, r);
    cmp_bit("analog_en", 1'b0, regulators.analog_en);
    cmp_bit("usb_en", 1'b0, regulators.usb_en);
    do_reset(1'b0);
    cmp_bit("usb_en", 1'b1, regulators.usb_en);
    axi_write(RC, 32'h00, r);
    cmp_bit("usb_en", 1'b1, regulators.usb_en);
    axi_write(PM, 32'h04, r);
    cmp_bit("bandgap_en", 1'b0, regulators.bandgap_en);
    cmp_bit("por_en", 1'b0, regulators.por_en);
    cmp_bit("usb_en", 1'b0, regulators.usb_en);
    results();
  end
endmodule : regulator_and_wake_pin_control_bench
